// file: design/hdc_defines.svh
// Register offsets, field positions and reset values of the haptic config bank
`ifndef HDC_DEFINES_SVH
`define HDC_DEFINES_SVH

`define HDC_OFS_UNLOCK 8'h0D
`define HDC_OFS_FULL_SCALE 8'h12
`define HDC_OFS_SUPPLY_DIS 8'h13
`define HDC_OFS_SKIP_TH 8'h14
`define HDC_OFS_RESTORE_DLY 8'h15

`define HDC_RST_FULL_SCALE 8'h00
`define HDC_RST_SUPPLY_DIS 8'h00
`define HDC_RST_SKIP_TH 7'h00
`define HDC_RST_DELAY 5'h00
`define HDC_RST_RESTORE_DIS 1'b0

`define HDC_BIT_RELEASE 0
`define HDC_BIT_RESTORE_DIS 7
`define HDC_MAG_MSB 6
`define HDC_DELAY_MSB 4
`define HDC_SKIP_MSB 6

// Step sizes: supply code in microvolts, amplitude code as a right shift
`define HDC_STEP_UV 21570
`define HDC_AMP_SHIFT 7

`endif

// file: design/hdc_pkg.sv
// Types shared by the haptic drive configuration bank
`default_nettype none
package hdc_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } hdc_reg_req_s;

   typedef struct packed {
      logic below_skip;
      logic bemf_enable;
      logic [4:0] skip_left;
   } hdc_bemf_stat_s;

   typedef enum logic [1:0] {
      HDC_RUN = 2'b01,
      HDC_LOCKED = 2'b10
   } hdc_lock_e;

endpackage : hdc_pkg
`default_nettype wire

// file: design/hdc_bemf_gate.sv
// Back-EMF measurement gating by amplitude threshold and start-up delay
`include "hdc_defines.svh"
`default_nettype none
module hdc_bemf_gate (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic active_i,
   input wire logic half_period_i,
   input wire logic pattern_start_i,
   input wire logic polarity_change_i,
   input wire logic [6:0] magnitude_i,
   input wire logic [6:0] skip_level_i,
   input wire logic [4:0] start_delay_i,
   output hdc_pkg::hdc_bemf_stat_s stat_o
);
   import hdc_pkg::*;

   logic below;
   logic rise;
   logic restart;
   logic below_q;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic en_q;

   //---------------------------------------------------------------
   // Skip decision
   //---------------------------------------------------------------
   assign below = magnitude_i < skip_level_i;
   assign rise = below_q & ~below;
   assign restart = pattern_start_i | polarity_change_i | rise;
   assign cnt_d = restart ? start_delay_i :
                  (half_period_i && cnt_q != 5'h00) ? cnt_q - 5'h01 : cnt_q;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         below_q <= 1'b0;
         cnt_q <= 5'h00;
         en_q <= 1'b0;
      end else begin
         below_q <= below;
         cnt_q <= cnt_d;
         en_q <= active_i & ~below & ~restart & (cnt_d == 5'h00);
      end
   end

   assign stat_o.below_skip = below_q;
   assign stat_o.bemf_enable = en_q;
   assign stat_o.skip_left = cnt_q;

endmodule : hdc_bemf_gate
`default_nettype wire

// file: design/hdc_cfg_regs.sv
// Haptic drive configuration registers, supply lockout and braking restore
`include "hdc_defines.svh"
`default_nettype none
module hdc_cfg_regs (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire hdc_pkg::hdc_reg_req_s reg_req_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [7:0] haptic_supply_input_i,
   input wire logic drive_request_i,
   input wire logic [7:0] amplitude_i,
   input wire logic pattern_start_i,
   input wire logic polarity_change_i,
   input wire logic half_period_i,
   input wire logic braking_i,
   input wire logic [4:0] braking_half_period_count_i,
   input wire logic [11:0] initial_frequency_guess_i,
   output logic drive_enable_o,
   output logic [7:0] full_scale_eff_o,
   output logic [7:0] drive_level_o,
   output logic supply_low_interrupt_o,
   output logic haptic_fault_flag_o,
   output logic freq_restore_o,
   output logic [11:0] freq_restore_value_o,
   output logic bemf_enable_o,
   output logic bemf_below_skip_o
);
   import hdc_pkg::*;

   //---------------------------------------------------------------
   // Configuration registers
   //---------------------------------------------------------------
   logic [7:0] full_scale_voltage_q;
   logic [7:0] supply_disable_threshold_q;
   logic [6:0] backemf_skip_level_q;
   logic guess_restore_disable_q;
   logic [4:0] measurement_start_delay_q;

   logic wr_fs;
   logic wr_dis;
   logic wr_skip;
   logic wr_rst;
   logic fault_release_bit;

   assign wr_fs = reg_req_i.wr && reg_req_i.addr == `HDC_OFS_FULL_SCALE;
   assign wr_dis = reg_req_i.wr && reg_req_i.addr == `HDC_OFS_SUPPLY_DIS;
   assign wr_skip = reg_req_i.wr && reg_req_i.addr == `HDC_OFS_SKIP_TH;
   assign wr_rst = reg_req_i.wr && reg_req_i.addr == `HDC_OFS_RESTORE_DLY;
   assign fault_release_bit = reg_req_i.wr &&
      reg_req_i.addr == `HDC_OFS_UNLOCK &&
      reg_req_i.wdata[`HDC_BIT_RELEASE];

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         full_scale_voltage_q <= `HDC_RST_FULL_SCALE;
         supply_disable_threshold_q <= `HDC_RST_SUPPLY_DIS;
         backemf_skip_level_q <= `HDC_RST_SKIP_TH;
         guess_restore_disable_q <= `HDC_RST_RESTORE_DIS;
         measurement_start_delay_q <= `HDC_RST_DELAY;
      end else begin
         if (wr_fs) full_scale_voltage_q <= reg_req_i.wdata;
         if (wr_dis) supply_disable_threshold_q <= reg_req_i.wdata;
         if (wr_skip) begin
            backemf_skip_level_q <= reg_req_i.wdata[`HDC_SKIP_MSB:0];
         end
         if (wr_rst) begin
            guess_restore_disable_q <= reg_req_i.wdata[`HDC_BIT_RESTORE_DIS];
            measurement_start_delay_q <=
               reg_req_i.wdata[`HDC_DELAY_MSB:0];
         end
      end
   end

   //---------------------------------------------------------------
   // Read-back
   //---------------------------------------------------------------
   logic [7:0] rd_mux;
   hdc_lock_e lock_q;

   assign rd_mux =
      (reg_req_i.addr == `HDC_OFS_FULL_SCALE) ? full_scale_voltage_q :
      (reg_req_i.addr == `HDC_OFS_SUPPLY_DIS) ? supply_disable_threshold_q :
      (reg_req_i.addr == `HDC_OFS_SKIP_TH) ? {1'b0, backemf_skip_level_q} :
      (reg_req_i.addr == `HDC_OFS_RESTORE_DLY) ?
         {guess_restore_disable_q, 2'b00, measurement_start_delay_q} :
      (reg_req_i.addr == `HDC_OFS_UNLOCK) ?
         {7'h00, lock_q == HDC_LOCKED} : 8'h00;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) reg_rdata_o <= 8'h00;
      else if (reg_req_i.rd) reg_rdata_o <= rd_mux;
   end

   //---------------------------------------------------------------
   // Full scale and amplitude scaling
   //---------------------------------------------------------------
   logic [7:0] fs_eff;
   logic [14:0] level_prod;

   assign fs_eff = (full_scale_voltage_q < haptic_supply_input_i) ?
      full_scale_voltage_q : haptic_supply_input_i;
   assign level_prod = fs_eff * amplitude_i[`HDC_MAG_MSB:0];

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         full_scale_eff_o <= 8'h00;
         drive_level_o <= 8'h00;
      end else begin
         full_scale_eff_o <= fs_eff;
         drive_level_o <= level_prod[14:`HDC_AMP_SHIFT];
      end
   end

   //---------------------------------------------------------------
   // Supply lockout
   //---------------------------------------------------------------
   logic supply_low;
   hdc_lock_e lock_d;

   assign supply_low = haptic_supply_input_i < supply_disable_threshold_q;

   always_comb begin
      case (lock_q)
         HDC_RUN: lock_d = supply_low ? HDC_LOCKED : HDC_RUN;
         HDC_LOCKED: begin
            // Set wins over release while the supply is still low
            lock_d = (fault_release_bit && !supply_low) ?
               HDC_RUN : HDC_LOCKED;
         end
         default: lock_d = HDC_LOCKED;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lock_q <= HDC_RUN;
         supply_low_interrupt_o <= 1'b0;
      end else begin
         lock_q <= lock_d;
         supply_low_interrupt_o <= lock_q == HDC_RUN &&
            lock_d == HDC_LOCKED;
      end
   end

   assign haptic_fault_flag_o = lock_q == HDC_LOCKED;
   assign drive_enable_o = drive_request_i && lock_q == HDC_RUN;

   //---------------------------------------------------------------
   // Braking half-period count and frequency restore
   //---------------------------------------------------------------
   logic [4:0] brk_cnt_q;
   logic brk_done;

   assign brk_done = braking_i && half_period_i &&
      brk_cnt_q + 5'h01 >= braking_half_period_count_i;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         brk_cnt_q <= 5'h00;
         freq_restore_o <= 1'b0;
         freq_restore_value_o <= 12'h000;
      end else begin
         if (!braking_i || brk_done) brk_cnt_q <= 5'h00;
         else if (half_period_i) brk_cnt_q <= brk_cnt_q + 5'h01;
         freq_restore_o <= brk_done && !guess_restore_disable_q;
         if (brk_done && !guess_restore_disable_q) begin
            freq_restore_value_o <= initial_frequency_guess_i;
         end
      end
   end

   //---------------------------------------------------------------
   // Back-EMF gating
   //---------------------------------------------------------------
   hdc_bemf_stat_s bemf_stat;

   hdc_bemf_gate u_bemf_gate (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .active_i(drive_enable_o),
      .half_period_i(half_period_i),
      .pattern_start_i(pattern_start_i),
      .polarity_change_i(polarity_change_i),
      .magnitude_i(amplitude_i[`HDC_MAG_MSB:0]),
      .skip_level_i(backemf_skip_level_q),
      .start_delay_i(measurement_start_delay_q),
      .stat_o(bemf_stat)
   );

   assign bemf_enable_o = bemf_stat.bemf_enable;
   assign bemf_below_skip_o = bemf_stat.below_skip;

endmodule : hdc_cfg_regs
`default_nettype wire

// file: dv/hdc_cfg_checker.sv
// Port-level checks for the haptic drive configuration bank
`include "hdc_defines.svh"
`default_nettype none
module hdc_cfg_checker (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire hdc_pkg::hdc_reg_req_s reg_req_i,
   input wire logic [7:0] haptic_supply_input_i,
   input wire logic drive_request_i,
   input wire logic [7:0] amplitude_i,
   input wire logic braking_i,
   input wire logic [11:0] initial_frequency_guess_i,
   input wire logic drive_enable_o,
   input wire logic [7:0] full_scale_eff_o,
   input wire logic [7:0] drive_level_o,
   input wire logic supply_low_interrupt_o,
   input wire logic haptic_fault_flag_o,
   input wire logic freq_restore_o,
   input wire logic [11:0] freq_restore_value_o,
   input wire logic bemf_enable_o
);
   import hdc_pkg::*;
   // ---------------------------------------------
   // Assertions and cover points
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   wire logic unlock_wr;
   assign unlock_wr = reg_req_i.wr && reg_req_i.wdata[`HDC_BIT_RELEASE] &&
      reg_req_i.addr == `HDC_OFS_UNLOCK;
   irq_on_lock_a: assert property (
      $rose(haptic_fault_flag_o) |-> supply_low_interrupt_o)
      else $error("no interrupt at lockout");
   irq_single_a: assert property (
      supply_low_interrupt_o |=> !supply_low_interrupt_o)
      else $error("interrupt longer than one cycle");
   lock_blocks_a: assert property (
      haptic_fault_flag_o |-> !drive_enable_o)
      else $error("driver enabled while locked");
   enable_req_a: assert property (
      drive_enable_o |-> drive_request_i)
      else $error("driver enabled without request");
   lock_held_a: assert property (
      haptic_fault_flag_o && !unlock_wr |=> haptic_fault_flag_o)
      else $error("lock left without release write");
   fs_capped_a: assert property (
      full_scale_eff_o <= $past(haptic_supply_input_i))
      else $error("full scale above supply");
   level_zero_a: assert property (
      $past(amplitude_i[6:0]) == 7'h00 |-> drive_level_o == 8'h00)
      else $error("drive level not zero");
   bemf_drive_a: assert property (
      bemf_enable_o |-> $past(drive_enable_o))
      else $error("back-emf enabled while driver off");
   restore_val_a: assert property (
      freq_restore_o |-> $past(braking_i) &&
      freq_restore_value_o == $past(initial_frequency_guess_i))
      else $error("restore value wrong");
   lock_c: cover property ($rose(haptic_fault_flag_o));
   restore_c: cover property (freq_restore_o);
   bemf_c: cover property ($rose(bemf_enable_o));
endmodule : hdc_cfg_checker
bind hdc_cfg_regs hdc_cfg_checker chk_u (.ref_clk_i, .rstn_i, .reg_req_i,
   .haptic_supply_input_i, .drive_request_i, .amplitude_i, .braking_i,
   .initial_frequency_guess_i, .drive_enable_o, .full_scale_eff_o,
   .drive_level_o, .supply_low_interrupt_o, .haptic_fault_flag_o,
   .freq_restore_o, .freq_restore_value_o, .bemf_enable_o);
`default_nettype wire

// file: dv/tb_haptic_drive_config_regs.sv
// Self-checking bench for the haptic drive configuration bank
`default_nettype none
module tb_haptic_drive_config_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import hdc_pkg::*;
   logic ref_clk_i = 0, rstn_i = 0, dreq = 0, pst = 0, half = 0, brk = 0;
   logic pol = 0;
   hdc_reg_req_s req = '0;
   logic [7:0] sup = 8'hFF, amp = 8'h00, rdata, fs_eff, lvl;
   logic [4:0] bcnt = 5'h00;
   logic [11:0] guess = 12'h000, fval;
   logic den, irq, flag, frest, ben, bbelow;
   int n_errors = 0, cmp_count = 0, i;
   hdc_cfg_regs dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .reg_req_i(req), .reg_rdata_o(rdata), .haptic_supply_input_i(sup),
      .drive_request_i(dreq), .amplitude_i(amp), .pattern_start_i(pst),
      .polarity_change_i(pol), .half_period_i(half), .braking_i(brk),
      .braking_half_period_count_i(bcnt),
      .initial_frequency_guess_i(guess), .drive_enable_o(den),
      .full_scale_eff_o(fs_eff), .drive_level_o(lvl),
      .supply_low_interrupt_o(irq), .haptic_fault_flag_o(flag),
      .freq_restore_o(frest), .freq_restore_value_o(fval),
      .bemf_enable_o(ben), .bemf_below_skip_o(bbelow));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   initial forever #5 ref_clk_i = ~ref_clk_i;
   task tick;
      @(posedge ref_clk_i);
      #1;
   endtask : tick
   task chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      req.addr = a;
      req.wdata = d;
      req.wr = 1;
      tick;
      req.wr = 0;
      tick;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      req.addr = a;
      req.rd = 1;
      tick;
      req.rd = 0;
      chk(rdata, e);
      tick;
   endtask : rd
   task complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_regs;
      static logic [7:0] a [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h20, 8'h0D};
      static logic [7:0] e [6] = '{8'hFF, 8'hFF, 8'h7F, 8'h9F, 8'h00, 8'h00};
      for (i = 0; i < 6; i++) rd(a[i], 8'h00);
      for (i = 0; i < 6; i++) begin
         wr(a[i], 8'hFF);
         rd(a[i], e[i]);
      end
      wr(8'h13, 8'h00);
      $display("t_regs done");
   endtask : t_regs
   task t_fs;
      wr(8'h12, 8'h80);
      amp = 8'h40;
      repeat (4) tick;
      chk(fs_eff, 8'h80);
      chk(lvl, 8'h40);
      sup = 8'h40;
      repeat (4) tick;
      chk(fs_eff, 8'h40);
      chk(lvl, 8'h20);
      $display("t_fs done");
   endtask : t_fs
   task t_lock;
      dreq = 1;
      sup = 8'h50;
      wr(8'h13, 8'h50);
      repeat (3) tick;
      chk(flag, 1'b0);
      chk(den, 1'b1);
      sup = 8'h4F;
      for (i = 0; i < 4 && flag !== 1'b1; i++) tick;
      chk({irq, flag, den}, 3'b110);
      tick;
      chk(irq, 1'b0);
      wr(8'h0D, 8'h01);
      rd(8'h0D, 8'h01);
      sup = 8'hFF;
      repeat (3) tick;
      chk({flag, den}, 2'b10);
      wr(8'h0D, 8'h01);
      chk({flag, den}, 2'b01);
      $display("t_lock done");
   endtask : t_lock
   task t_brake(input logic [7:0] cfg, input logic exp);
      guess = 12'hABC;
      bcnt = 5'h02;
      wr(8'h15, cfg);
      brk = 1;
      half = 1;
      tick;
      tick;
      half = 0;
      for (i = 0; i < 6 && frest !== 1'b1; i++) tick;
      chk(frest, exp);
      if (exp) chk(fval, 12'hABC);
      brk = 0;
      tick;
      $display("t_brake done");
   endtask : t_brake
   task t_bemf;
      wr(8'h14, 8'h10);
      wr(8'h15, 8'h02);
      amp = 8'h20;
      pst = 1;
      tick;
      pst = 0;
      tick;
      chk(ben, 1'b0);
      repeat (2) begin
         half = 1;
         tick;
         half = 0;
         tick;
      end
      for (i = 0; i < 4 && ben !== 1'b1; i++) tick;
      chk({ben, bbelow}, 2'b10);
      amp = 8'h88;
      for (i = 0; i < 4 && bbelow !== 1'b1; i++) tick;
      tick;
      chk({ben, bbelow}, 2'b01);
      amp = 8'h20;
      repeat (3) tick;
      chk(ben, 1'b0);
      repeat (2) begin
         half = 1;
         tick;
         half = 0;
         tick;
      end
      chk(ben, 1'b1);
      pol = 1;
      tick;
      pol = 0;
      tick;
      chk(ben, 1'b0);
      $display("t_bemf done");
   endtask : t_bemf
   initial begin
      repeat (20) @(posedge ref_clk_i);
      #1;
      rstn_i = 1;
      t_regs;
      t_fs;
      t_lock;
      t_brake(8'h00, 1'b1);
      t_brake(8'h80, 1'b0);
      t_bemf;
      complete_run;
   end
   initial begin
      #100us;
      n_errors++;
      complete_run;
   end
endmodule : tb_haptic_drive_config_regs
`default_nettype wire
